// file: acd_params.svh
`ifndef ACD_PARAMS_SVH
`define ACD_PARAMS_SVH

// Register byte offsets
`define ACD_OFF_CB0 8'h00
`define ACD_OFF_CB1 8'h04
`define ACD_OFF_CB2 8'h08
`define ACD_OFF_CB3 8'h0C
`define ACD_OFF_CTRL 8'h10
`define ACD_OFF_STATUS 8'h14
`define ACD_OFF_IRQ_STAT 8'h18
`define ACD_OFF_IRQ_MASK 8'h1C
`define ACD_OFF_RDATA0 8'h20
`define ACD_OFF_RDATA1 8'h24
`define ACD_OFF_SIGCFG 8'h28

// Command block byte positions
`define ACD_BYTE_SIG 4'h0
`define ACD_BYTE_SUB 4'h1
`define ACD_BYTE_ACTION 4'h2
`define ACD_BYTE_MASK 4'h3
`define ACD_BYTE_BCNT 4'h4
`define ACD_BYTE_WDATA 4'h5

// Field positions
`define ACD_CTRL_START 0
`define ACD_ACT_RDONLY 0
`define ACD_ST_BUSY 0
`define ACD_ST_FAIL 1
`define ACD_ST_NOTV 2
`define ACD_ST_SECT_LSB 16
`define ACD_IRQ_DONE 0
`define ACD_IRQ_FAIL 1
`define ACD_IRQ_NOTV 2

// Values
`define ACD_SUBCMD 8'h24
`define ACD_SIG_RST 8'h00
`define ACD_IRQ_MASK_RST 3'h0
`define ACD_SECT_ZERO 9'h100
`define ACD_ATA_ALT_ADDR 10'h3F6
`define ACD_ATA_BASE_ADDR 10'h1F0
`define ACD_LAST_SEL 3'h7

`endif

// file: acd_pkg.sv
`default_nettype none
package acd_pkg;
	typedef enum logic [2:0] {
		ACD_IDLE,
		ACD_CHECK,
		ACD_SCAN,
		ACD_WAIT,
		ACD_DONE
	} acd_state_t;
	typedef logic [7:0] acd_byte_t;
endpackage
`default_nettype wire

// file: acd_bcnt_chk.sv
`timescale 1ns/10ps
`default_nettype none
`include "acd_params.svh"
module acd_bcnt_chk
	import acd_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Block count byte in, verdict out
	input wire acd_byte_t count,
	output logic legal_r,
	output logic [8:0] sectors_r
);
	logic legal_nxt;

	// Zero or a single set bit
	assign legal_nxt = ((count & 8'(count - 8'h01)) == 8'h00);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			legal_r <= 1'b0;
			sectors_r <= 9'h000;
		end else begin
			legal_r <= legal_nxt;
			// Sectors per block, zero standing for the largest block
			sectors_r <= (count == 8'h00) ? `ACD_SECT_ZERO : {1'b0, count};
		end
	end

	default clocking cb_clk @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_zero_means_256: assert property (count == 8'h00 |=> sectors_r == 9'h100)
		else $error("block count zero not reported as 256 sectors");
	a_illegal_count: assert property (count == 8'h03 || count == 8'h81 |=> !legal_r)
		else $error("illegal block count accepted");
endmodule
`default_nettype wire

// file: acd_top.sv
// Behaviour
// - Access only registers whose mask bit set
// - Read result always eight bytes, unselected zero
// - Accesses run ascending from bit 0
// - Mask bits map to taskfile addresses
// - Byte 4 gives sectors per block
// - Only zero or powers of two; zero=256
// - Illegal count fails the command
// - Bytes 5 to 12 carry write values
// - Write bytes map to taskfile addresses
// - Vendor block needs signature and subcommand
// - Read-only flag reads, never writes
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "acd_params.svh"
module acd_top
	import acd_pkg::*;
#(
	parameter int ADDR_W = 12
)(
	// APB clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Interrupt
	output logic irq,
	// Taskfile access port toward the drive
	output logic tf_req,
	output logic tf_wr,
	output logic [2:0] tf_sel,
	output logic [9:0] tf_addr,
	output logic [7:0] tf_wdata,
	input wire logic [7:0] tf_rdata,
	input wire logic tf_ack
);
	acd_state_t state_r, state_nxt;
	acd_byte_t cb_r [16];
	acd_byte_t rd_buf_r [8];
	acd_byte_t sig_r;
	logic [2:0] irq_stat_r, irq_mask_r, irq_ev;
	logic [2:0] idx_r;
	logic res_fail_r, res_notv_r;
	logic tf_req_r, tf_wr_r;
	logic [2:0] tf_sel_r;
	logic [9:0] tf_addr_r;
	logic [7:0] tf_wdata_r;
	logic [31:0] prdata_r, rd_mux;
	logic [7:0] off;
	logic wr_acc, setup_rd, mapped, start, busy;
	logic vendor, bc_legal, ro, hit, last, store;
	logic [7:0] mask;
	logic [8:0] sectors;

	assign off = paddr[7:0];
	assign wr_acc = psel && penable && pwrite;
	assign setup_rd = psel && !penable && !pwrite;
	assign busy = (state_r != ACD_IDLE);
	assign start = wr_acc && mapped && (off == `ACD_OFF_CTRL) && pwdata[`ACD_CTRL_START] && !busy;
	assign mask = cb_r[`ACD_BYTE_MASK];
	assign ro = cb_r[`ACD_BYTE_ACTION][`ACD_ACT_RDONLY];
	assign vendor = (cb_r[`ACD_BYTE_SIG] == sig_r) && (cb_r[`ACD_BYTE_SUB] == `ACD_SUBCMD);
	assign hit = mask[idx_r];
	assign last = (idx_r == `ACD_LAST_SEL);
	assign store = (state_r == ACD_WAIT) && tf_ack && ro;

	// Registers sit at word offsets; everything else answers with an error
	always_comb begin
		mapped = (paddr[ADDR_W-1:8] == '0) && (paddr[1:0] == 2'b00);
		rd_mux = 32'h0000_0000;
		unique case (off)
			`ACD_OFF_CB0, `ACD_OFF_CB1, `ACD_OFF_CB2, `ACD_OFF_CB3: begin
				rd_mux = {cb_r[{off[3:2], 2'd3}], cb_r[{off[3:2], 2'd2}],
					cb_r[{off[3:2], 2'd1}], cb_r[{off[3:2], 2'd0}]};
			end
			`ACD_OFF_CTRL: begin
				rd_mux = 32'h0000_0000;
			end
			`ACD_OFF_STATUS: begin
				rd_mux[`ACD_ST_BUSY] = busy;
				rd_mux[`ACD_ST_FAIL] = res_fail_r;
				rd_mux[`ACD_ST_NOTV] = res_notv_r;
				rd_mux[`ACD_ST_SECT_LSB +: 9] = sectors;
			end
			`ACD_OFF_IRQ_STAT: begin
				rd_mux[2:0] = irq_stat_r;
			end
			`ACD_OFF_IRQ_MASK: begin
				rd_mux[2:0] = irq_mask_r;
			end
			`ACD_OFF_RDATA0: begin
				rd_mux = {rd_buf_r[3], rd_buf_r[2], rd_buf_r[1], rd_buf_r[0]};
			end
			`ACD_OFF_RDATA1: begin
				rd_mux = {rd_buf_r[7], rd_buf_r[6], rd_buf_r[5], rd_buf_r[4]};
			end
			`ACD_OFF_SIGCFG: begin
				rd_mux[7:0] = sig_r;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	// Read data is latched in the setup cycle so the access phase sees a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
		end else if (setup_rd) begin
			prdata_r <= mapped ? rd_mux : 32'h0000_0000;
		end
	end

	assign prdata = prdata_r;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// Command block is frozen while a command runs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 16; i++) begin
				cb_r[i] <= 8'h00;
			end
		end else if (wr_acc && mapped && !busy && (off[7:4] == 4'h0)) begin
			for (int b = 0; b < 4; b++) begin
				if (pstrb[b]) begin
					cb_r[{off[3:2], 2'(b)}] <= pwdata[8*b +: 8];
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sig_r <= `ACD_SIG_RST;
		end else if (wr_acc && mapped && (off == `ACD_OFF_SIGCFG) && pstrb[0]) begin
			sig_r <= pwdata[7:0];
		end
	end

	acd_bcnt_chk u_bcnt (
		.pclk(pclk),
		.presetn(presetn),
		.count(cb_r[`ACD_BYTE_BCNT]),
		.legal_r(bc_legal),
		.sectors_r(sectors)
	);

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ACD_IDLE: begin
				if (start) begin
					state_nxt = ACD_CHECK;
				end
			end
			ACD_CHECK: begin
				if (!vendor || !bc_legal) begin
					state_nxt = ACD_DONE;
				end else begin
					state_nxt = ACD_SCAN;
				end
			end
			ACD_SCAN: begin
				if (hit) begin
					state_nxt = ACD_WAIT;
				end else if (last) begin
					state_nxt = ACD_DONE;
				end
			end
			ACD_WAIT: begin
				if (tf_ack) begin
					state_nxt = last ? ACD_DONE : ACD_SCAN;
				end
			end
			ACD_DONE: begin
				state_nxt = ACD_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ACD_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// One mask bit per step, lowest first; command register comes out last
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idx_r <= 3'h0;
		end else if (state_r == ACD_CHECK) begin
			idx_r <= 3'h0;
		end else if (!last && (((state_r == ACD_SCAN) && !hit) ||
				((state_r == ACD_WAIT) && tf_ack))) begin
			idx_r <= idx_r + 3'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tf_req_r <= 1'b0;
			tf_wr_r <= 1'b0;
			tf_sel_r <= 3'h0;
			tf_addr_r <= 10'h000;
			tf_wdata_r <= 8'h00;
		end else if ((state_r == ACD_SCAN) && hit) begin
			tf_req_r <= 1'b1;
			tf_wr_r <= !ro;
			tf_sel_r <= idx_r;
			tf_addr_r <= (idx_r == 3'h0) ? `ACD_ATA_ALT_ADDR :
				(`ACD_ATA_BASE_ADDR | {7'h00, idx_r});
			// Only selected bytes are ever sent; the rest are never looked at
			tf_wdata_r <= cb_r[4'(`ACD_BYTE_WDATA + {1'b0, idx_r})];
		end else if ((state_r == ACD_WAIT) && tf_ack) begin
			tf_req_r <= 1'b0;
		end
	end

	assign tf_req = tf_req_r;
	assign tf_wr = tf_wr_r;
	assign tf_sel = tf_sel_r;
	assign tf_addr = tf_addr_r;
	assign tf_wdata = tf_wdata_r;

	// Buffer is cleared at check so unselected entries read back as zero
	for (genvar g = 0; g < 8; g++) begin : g_rdbuf
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				rd_buf_r[g] <= 8'h00;
			end else if (state_r == ACD_CHECK) begin
				rd_buf_r[g] <= 8'h00;
			end else if (store && (idx_r == 3'(g))) begin
				rd_buf_r[g] <= tf_rdata;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			res_fail_r <= 1'b0;
			res_notv_r <= 1'b0;
		end else if (start) begin
			res_fail_r <= 1'b0;
			res_notv_r <= 1'b0;
		end else if (state_r == ACD_CHECK) begin
			res_notv_r <= !vendor;
			res_fail_r <= vendor && !bc_legal;
		end
	end

	assign irq_ev[`ACD_IRQ_DONE] = (state_r == ACD_DONE);
	assign irq_ev[`ACD_IRQ_FAIL] = (state_r == ACD_CHECK) && vendor && !bc_legal;
	assign irq_ev[`ACD_IRQ_NOTV] = (state_r == ACD_CHECK) && !vendor;

	// A new event beats a write-one-to-clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_r <= 3'h0;
		end else begin
			irq_stat_r <= irq_ev | (irq_stat_r &
				~((wr_acc && mapped && (off == `ACD_OFF_IRQ_STAT)) ? pwdata[2:0] : 3'h0));
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_r <= `ACD_IRQ_MASK_RST;
		end else if (wr_acc && mapped && (off == `ACD_OFF_IRQ_MASK) && pstrb[0]) begin
			irq_mask_r <= pwdata[2:0];
		end
	end

	assign irq = |(irq_stat_r & irq_mask_r);

	// Checking helpers
	logic [7:0] unsel_nz;
	logic [2:0] last_sel_r;
	logic seen_r;
	for (genvar h = 0; h < 8; h++) begin : g_unsel
		assign unsel_nz[h] = !mask[h] && (rd_buf_r[h] != 8'h00);
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_sel_r <= 3'h0;
			seen_r <= 1'b0;
		end else if (state_r == ACD_CHECK) begin
			seen_r <= 1'b0;
		end else if (tf_req_r && tf_ack) begin
			last_sel_r <= tf_sel_r;
			seen_r <= 1'b1;
		end
	end

	default clocking cb_clk @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_check_bad;
		(state_r == ACD_CHECK) && vendor && !bc_legal;
	endsequence
	sequence s_fail_end;
		(state_r == ACD_DONE) && res_fail_r && !tf_req_r ##1 (state_r == ACD_IDLE);
	endsequence
	sequence s_last_ack;
		tf_req_r && (tf_sel_r == 3'h7) && tf_ack;
	endsequence

	a_mask_gates_access: assert property (tf_req_r |-> mask[tf_sel_r])
		else $error("taskfile access to an unselected register");
	a_unsel_reads_zero: assert property ((state_r == ACD_DONE) && ro |-> unsel_nz == 8'h00)
		else $error("unselected read byte not zero");
	a_order_ascends: assert property ($rose(tf_req_r) && seen_r |-> tf_sel_r > last_sel_r)
		else $error("taskfile accesses out of ascending order");
	a_addr_ends: assert property (tf_req_r |-> (tf_sel_r == 3'h0) == (tf_addr_r == 10'h3F6) &&
		((tf_sel_r == 3'h7) == (tf_addr_r == 10'h1F7)))
		else $error("mask bit mapped to wrong taskfile address");
	a_bad_count_fails: assert property (s_check_bad |=> s_fail_end)
		else $error("illegal block count not failed");
	a_wdata_from_byte: assert property (tf_req_r && tf_wr_r |->
		tf_wdata_r == cb_r[4'(5 + tf_sel_r)])
		else $error("write data taken from wrong command byte");
	a_readonly_no_wr: assert property (tf_req_r && ro |-> !tf_wr_r)
		else $error("write issued in read-only mode");
	a_vendor_gate: assert property ((state_r == ACD_CHECK) && !vendor |=>
		(state_r == ACD_DONE) && res_notv_r ##1 !tf_req_r)
		else $error("non-vendor block was executed");
	a_cmd_reg_last: assert property (s_last_ack |=> (state_r == ACD_DONE) ##1 !tf_req_r)
		else $error("access after command register");
	a_req_held: assert property (tf_req_r && !tf_ack |=> tf_req_r && $stable(tf_addr_r))
		else $error("taskfile request dropped before ack");
endmodule
`default_nettype wire

// file: acd_drive_model.sv
`timescale 1ns/10ps
`default_nettype none
module acd_drive_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Taskfile port from the decoder
	input wire logic tf_req,
	input wire logic tf_wr,
	input wire logic [2:0] tf_sel,
	input wire logic [9:0] tf_addr,
	input wire logic [7:0] tf_wdata,
	output logic [7:0] tf_rdata,
	output logic tf_ack,
	// Extra wait cycles before each acknowledge
	input wire logic [3:0] dly
);
	logic [7:0] regs [8];
	logic [21:0] log [$];
	int cnt;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tf_ack <= 1'b0;
			tf_rdata <= 8'h5A;
			cnt <= 0;
		end else begin
			tf_ack <= 1'b0;
			// Read data is only valid with the acknowledge
			tf_rdata <= ~tf_rdata;
			if (tf_req && !tf_ack) begin
				if (cnt < dly) begin
					cnt <= cnt + 1;
				end else begin
					cnt <= 0;
					tf_ack <= 1'b1;
					if (tf_wr) begin
						regs[tf_sel] <= tf_wdata;
					end else begin
						tf_rdata <= regs[tf_sel];
					end
					log.push_back({tf_wr, tf_sel, tf_addr, tf_wr ? tf_wdata : regs[tf_sel]});
				end
			end
		end
	end
	initial for (int i = 0; i < 8; i++) regs[i] = 8'h30 + 8'(i);
endmodule
`default_nettype wire

// file: tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "acd_params.svh"
module tb;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, irq, tf_req, tf_wr, tf_ack;
	logic [2:0] tf_sel;
	logic [9:0] tf_addr;
	logic [7:0] tf_wdata, tf_rdata;
	logic [3:0] dly = 4'h0;
	logic [7:0] bcs [12] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80,
		8'h03, 8'h81, 8'hFF};
	logic [63:0] w1 = 64'h1122334455667788, w2 = 64'hC1D2E3F405162738;
	logic legal;
	int err_count = 0, n_tests = 0;
	always #50 pclk = ~pclk;
	acd_top acd_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb(4'hF), .prdata, .pready, .pslverr, .irq, .tf_req, .tf_wr, .tf_sel, .tf_addr,
		.tf_wdata, .tf_rdata, .tf_ack);
	acd_drive_model acd_drive_model_i (.pclk, .presetn, .tf_req, .tf_wr, .tf_sel, .tf_addr,
		.tf_wdata, .tf_rdata, .tf_ack, .dly);
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {4'h0, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// No wait limit here; only the watchdog ends a stalled transfer
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic run(input logic [7:0] sig, sub, act, mask, bc, input logic [63:0] w);
		int n;
		acd_drive_model_i.log.delete();
		apb(1, `ACD_OFF_CB0, {mask, act, sub, sig});
		apb(1, `ACD_OFF_CB1, {w[23:0], bc});
		apb(1, `ACD_OFF_CB2, w[55:24]);
		apb(1, `ACD_OFF_CB3, {24'h0, w[63:56]});
		apb(1, `ACD_OFF_CTRL, 32'h1);
		n = 0;
		do begin
			apb(0, `ACD_OFF_STATUS, 32'h0);
			n++;
		end while (rd[0] !== 1'b0 && n < 200);
		chk("busy", 32'h0, {31'h0, rd[0]});
	endtask
	task automatic chk_log(input logic [7:0] mask, input logic ro, input logic [63:0] w);
		int k;
		logic [9:0] a;
		k = 0;
		for (int i = 0; i < 8; i++) if (mask[i]) begin
			a = (i == 0) ? 10'h3F6 : 10'h1F0 + 10'(i);
			chk("tf access", 32'({~ro, 3'(i), a, w[8*i+:8]}), k < acd_drive_model_i.log.size() ?
				32'(acd_drive_model_i.log[k]) : 32'hXXXXXXXX);
			k++;
		end
		chk("tf count", k, acd_drive_model_i.log.size());
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		#(100 * 40000);
		err_count++;
		end_of_test();
	end
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, `ACD_OFF_IRQ_MASK, 32'h0);
		chk("irq mask reset", 32'h0, rd);
		apb(0, 8'h30, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, err});
		apb(1, `ACD_OFF_SIGCFG, 32'h5C);
		$display("test registers done");
		foreach (bcs[j]) begin
			run(8'h5C, `ACD_SUBCMD, 8'h00, 8'h00, bcs[j], 64'h0);
			// The first nine entries are the legal counts
			legal = (j < 9);
			chk("count fail", {31'h0, !legal}, {31'h0, rd[1]});
			if (legal)
				chk("sectors", bcs[j] == 8'h00 ? 32'h100 : 32'(bcs[j]), 32'(rd[24:16]));
			apb(0, `ACD_OFF_IRQ_STAT, 32'h0);
			chk("fail event", {30'h0, !legal, 1'b1}, {30'h0, rd[1:0]});
			apb(1, `ACD_OFF_IRQ_STAT, 32'h7);
		end
		$display("test block count done");
		run(8'h5C, `ACD_SUBCMD, 8'h00, 8'h81, 8'h01, w1);
		chk_log(8'h81, 1'b0, w1);
		dly <= 4'h3;
		run(8'h5C, `ACD_SUBCMD, 8'h00, 8'hFF, 8'h10, w2);
		chk_log(8'hFF, 1'b0, w2);
		run(8'h5C, `ACD_SUBCMD, 8'h01, 8'h5A, 8'h01, 64'hA5A5A5A5A5A5A5A5);
		chk_log(8'h5A, 1'b1, w2);
		apb(0, `ACD_OFF_RDATA0, 32'h0);
		chk("read bytes low", w2[31:0] & 32'hFF00FF00, rd);
		apb(0, `ACD_OFF_RDATA1, 32'h0);
		chk("read bytes high", w2[63:32] & 32'h00FF00FF, rd);
		$display("test taskfile done");
		for (int i = 0; i < 2; i++) begin
			run(i ? 8'h5C : 8'h5D, i ? 8'h25 : `ACD_SUBCMD, 8'h00, 8'hFF, 8'h01, w1);
			chk("not vendor", 32'h1, {31'h0, rd[2]});
			chk("no access", 32'h0, acd_drive_model_i.log.size());
			apb(0, `ACD_OFF_IRQ_STAT, 32'h0);
			chk("not vendor event", 32'h1, {31'h0, rd[2]});
			apb(1, `ACD_OFF_IRQ_STAT, 32'h7);
		end
		$display("test vendor check done");
		apb(1, `ACD_OFF_IRQ_STAT, 32'h7);
		apb(1, `ACD_OFF_IRQ_MASK, 32'h2);
		run(8'h5C, `ACD_SUBCMD, 8'h00, 8'h00, 8'h01, 64'h0);
		@(negedge pclk);
		chk("irq masked", 32'h0, {31'h0, irq});
		apb(1, `ACD_OFF_IRQ_MASK, 32'h1);
		@(negedge pclk);
		chk("irq raised", 32'h1, {31'h0, irq});
		apb(1, `ACD_OFF_IRQ_STAT, 32'h1);
		@(negedge pclk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		$display("test interrupt done");
		end_of_test();
	end
endmodule
`default_nettype wire
